// >>> hdl/pgck_pkg.sv
// Package of entry field positions, encodings and register map for the 64KB page checker.
package pgck_pkg;

   // ----------------------------------------------------------------------
   // Entry field positions
   // ----------------------------------------------------------------------
   localparam int EXEC_BLOCK_BIT   = 63;
   localparam int IGN_HI_MSB       = 62;
   localparam int IGN_HI_LSB       = 52;
   localparam int RSVD_MSB         = 51;
   localparam int FRAME_LSB        = 16;
   localparam int RSVD_LO_MSB      = 15;
   localparam int RSVD_LO_LSB      = 12;
   localparam int UNUSED_BIT       = 11;
   localparam int EXT_ACCESS_BIT   = 10;
   localparam int IGN_LO_BIT       = 9;
   localparam int GLOBAL_BIT       = 8;
   localparam int ATTR_INDEX_BIT   = 7;
   localparam int DIRTY_BIT        = 6;
   localparam int ACCESSED_BIT     = 5;
   localparam int CACHE_DIS_BIT    = 4;
   localparam int WRITE_THRU_BIT   = 3;
   localparam int USER_BIT         = 2;
   localparam int WRITE_BIT        = 1;
   localparam int PRESENT_BIT      = 0;

   // ----------------------------------------------------------------------
   // Address widths
   // ----------------------------------------------------------------------
   localparam int HAW_CLIENT       = 39;
   localparam int HAW_SERVER       = 46;
   localparam int ENTRY_W          = 64;
   localparam int OFFSET_W         = 16;

   // ----------------------------------------------------------------------
   // Fault cause encoding
   // ----------------------------------------------------------------------
   localparam logic [2:0] FLT_NONE    = 3'h0;
   localparam logic [2:0] FLT_PRESENT = 3'h1;
   localparam logic [2:0] FLT_USER    = 3'h2;
   localparam logic [2:0] FLT_WRITE   = 3'h3;
   localparam logic [2:0] FLT_EXEC    = 3'h4;

   // ----------------------------------------------------------------------
   // Register map and reset values
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_IMASK  = 12'h008;
   localparam logic [11:0] OFS_COUNT  = 12'h00C;
   localparam int          CTRL_W     = 5;
   localparam int          EVT_W      = 3;
   localparam logic [4:0]  CTRL_RST   = 5'h00;
   localparam logic [2:0]  IMASK_RST  = 3'h0;
   localparam int CTRL_EXEC_EN  = 0;
   localparam int CTRL_NEST_EN  = 1;
   localparam int CTRL_EAF_EN   = 2;
   localparam int CTRL_SWP_EN   = 3;
   localparam int CTRL_GPE      = 4;
   localparam int EVT_FAULT     = 0;
   localparam int EVT_DONE      = 1;
   localparam int EVT_UPDATE    = 2;

endpackage : pgck_pkg

// >>> hdl/pgck_decode.sv
// Combinational decode of a 64KB page entry against one request.
`timescale 1ns/1ps
module pgck_decode #(
   parameter int HOST_ADDR_WIDTH = pgck_pkg::HAW_CLIENT
) (
   input  wire logic [63:0]    entry,
   input  wire logic [15:0]    req_offset,
   input  wire logic           req_user,
   input  wire logic           req_write,
   input  wire logic           req_fetch,
   input  wire logic           exec_protect_enable,
   input  wire logic           supervisor_write_protect_enable,
   input  wire logic           ext_access_flag_enable,
   output logic [HOST_ADDR_WIDTH-1:0]      phys_addr,
   output logic [2:0]          mem_type,
   output logic [2:0]          fault_code,
   output logic [63:0]         entry_upd,
   output logic                upd_needed
);

   // ----------------------------------------------------------------------
   // Address and memory type
   // ----------------------------------------------------------------------
   // RULE3 frame and offset
   assign phys_addr = {entry[HOST_ADDR_WIDTH-1:pgck_pkg::FRAME_LSB], req_offset};
   // RULE9 memory type bits
   assign mem_type  = {entry[pgck_pkg::ATTR_INDEX_BIT], entry[pgck_pkg::CACHE_DIS_BIT],
                       entry[pgck_pkg::WRITE_THRU_BIT]};

   // ----------------------------------------------------------------------
   // Permission checks
   // ----------------------------------------------------------------------
   // RULE2 RULE6 RULE8 bits left unread
   // Bits 62:52, 11, 9 and 8 are never read here, so they cannot sway a result.
   always_comb begin
      fault_code = pgck_pkg::FLT_NONE;
      // RULE17 fault on absent entry
      if (!entry[pgck_pkg::PRESENT_BIT]) begin
         fault_code = pgck_pkg::FLT_PRESENT;
      // RULE12 user access denied
      end else if (req_user && !entry[pgck_pkg::USER_BIT]) begin
         fault_code = pgck_pkg::FLT_USER;
      // RULE13 write permission check
      // RULE14 supervisor path kept
      end else if (req_write && !entry[pgck_pkg::WRITE_BIT] &&
                   (req_user || supervisor_write_protect_enable)) begin
         fault_code = pgck_pkg::FLT_WRITE;
      // RULE1 execute blocked
      end else if (req_fetch && exec_protect_enable && entry[pgck_pkg::EXEC_BLOCK_BIT]) begin
         fault_code = pgck_pkg::FLT_EXEC;
      end
   end

   // ----------------------------------------------------------------------
   // Flag updates
   // ----------------------------------------------------------------------
   always_comb begin
      entry_upd = entry;
      // RULE11 accessed flag
      entry_upd[pgck_pkg::ACCESSED_BIT] = 1'b1;
      // RULE10 dirty on write
      if (req_write) begin
         entry_upd[pgck_pkg::DIRTY_BIT] = 1'b1;
      end
      // RULE7 extended access flag
      if (ext_access_flag_enable) begin
         entry_upd[pgck_pkg::EXT_ACCESS_BIT] = 1'b1;
      end
   end
   assign upd_needed = (fault_code == pgck_pkg::FLT_NONE) && (entry_upd != entry);

endmodule : pgck_decode

// >>> hdl/pgck_top.sv
// Top of the 64KB page entry checker with APB control registers.
// Operation
// RULE1 - With execute protection enabled, a fetch to a page whose bit 63 is set is refused.
// RULE2 - Bits 62 to 52 and bit 9 have no effect on any result.
// RULE3 - The page address is entry bits width-1 to 16 joined to the 16-bit request offset.
// RULE4 - The host address width is 39 for client builds and 46 for server builds.
// RULE5 - With nested translation enabled, the frame is flagged as a guest-physical address.
// RULE6 - Bit 11 is not used for anything.
// RULE7 - With the extended flag enable set, bit 10 is set on use, otherwise it is ignored.
// RULE8 - The global flag in bit 8 is ignored and keeps nothing cached.
// RULE9 - Memory type is taken from bits 7, 4 and 3 and forwarded with coherent requests.
// RULE10 - A successful write sets the dirty flag in bit 6.
// RULE11 - The first access sets the accessed flag in bit 5.
// RULE12 - With bit 2 clear, user-level requests are rejected.
// RULE13 - With bit 1 clear, user writes are denied, and supervisor writes when protect is on.
// RULE14 - Only user-mode contexts are supported; the code also serves supervisor requests (req_user low).
// RULE15 - Software sets bit 0 to make the entry a valid mapping.
// RULE16 - Software writes zero to reserved bits 51 to width and 15 to 12.
// RULE17 - A missing entry or failed check gives a fault and no access.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pgck_top #(
   parameter int HOST_ADDR_WIDTH = pgck_pkg::HAW_CLIENT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic [63:0] req_entry,
   input  wire logic [15:0] req_offset,
   input  wire logic        req_user,
   input  wire logic        req_write,
   input  wire logic        req_fetch,
   input  wire logic        req_coherent,
   output logic             rsp_valid,
   output logic             rsp_fault,
   output logic [2:0]       rsp_fault_code,
   output logic [HOST_ADDR_WIDTH-1:0]   rsp_addr,
   output logic             rsp_guest_phys,
   output logic [2:0]       rsp_mem_type,
   output logic             upd_valid,
   output logic [63:0]      upd_entry,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Configuration check
   // ----------------------------------------------------------------------
   // RULE4 width limited to builds
   if (HOST_ADDR_WIDTH != pgck_pkg::HAW_CLIENT && HOST_ADDR_WIDTH != pgck_pkg::HAW_SERVER) begin : g_bad_haw
      $error("host address width must be 39 or 46");
   end

   logic [4:0]  ctrl_reg;
   logic [2:0]  status_reg;
   logic [2:0]  imask_reg;
   logic [15:0] count_reg;
   logic [HOST_ADDR_WIDTH-1:0] dec_addr;
   logic [2:0]  dec_type;
   logic [2:0]  dec_fault;
   logic [63:0] dec_upd;
   logic        dec_upd_needed;
   logic [2:0]  evt;
   logic        wr_acc;
   logic        rd_acc;
   logic        addr_ok;

   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------------
   // Entry decode
   // ----------------------------------------------------------------------
   pgck_decode #(
      .HOST_ADDR_WIDTH (HOST_ADDR_WIDTH)
   ) u_decode (
      .entry                           (req_entry),
      .req_offset                      (req_offset),
      .req_user                        (req_user),
      .req_write                       (req_write),
      .req_fetch                       (req_fetch),
      .exec_protect_enable             (ctrl_reg[pgck_pkg::CTRL_EXEC_EN]),
      .supervisor_write_protect_enable (ctrl_reg[pgck_pkg::CTRL_SWP_EN]),
      .ext_access_flag_enable          (ctrl_reg[pgck_pkg::CTRL_EAF_EN]),
      .phys_addr                       (dec_addr),
      .mem_type                        (dec_type),
      .fault_code                      (dec_fault),
      .entry_upd                       (dec_upd),
      .upd_needed                      (dec_upd_needed)
   );

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   assign addr_ok = (paddr == pgck_pkg::OFS_CTRL) || (paddr == pgck_pkg::OFS_STATUS) ||
                    (paddr == pgck_pkg::OFS_IMASK) || (paddr == pgck_pkg::OFS_COUNT);
   // Writes land at the edge that ends the access phase, where the master sees pready.
   assign wr_acc  = psel && penable && pready && pwrite;
   assign rd_acc  = psel && !penable && !pwrite;

   // Every access ends in its first access cycle with no wait cycle; prdata is registered in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (rd_acc) begin
            unique case (paddr)
               pgck_pkg::OFS_CTRL:   prdata <= {27'h0, ctrl_reg};
               pgck_pkg::OFS_STATUS: prdata <= {29'h0, status_reg};
               pgck_pkg::OFS_IMASK:  prdata <= {29'h0, imask_reg};
               pgck_pkg::OFS_COUNT:  prdata <= {16'h0, count_reg};
               default:              prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= pgck_pkg::CTRL_RST;
         imask_reg <= pgck_pkg::IMASK_RST;
      end else if (wr_acc) begin
         if (paddr == pgck_pkg::OFS_CTRL) begin
            ctrl_reg <= pwdata[pgck_pkg::CTRL_W-1:0];
         end
         if (paddr == pgck_pkg::OFS_IMASK) begin
            imask_reg <= pwdata[pgck_pkg::EVT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Request pipeline
   // ----------------------------------------------------------------------
   // The answer is registered one cycle after req_valid; no request is held back.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid      <= 1'b0;
         rsp_fault      <= 1'b0;
         rsp_fault_code <= pgck_pkg::FLT_NONE;
         rsp_addr       <= '0;
         rsp_guest_phys <= 1'b0;
         rsp_mem_type   <= 3'h0;
         upd_valid      <= 1'b0;
         upd_entry      <= 64'h0000_0000_0000_0000;
      end else begin
         rsp_valid <= req_valid;
         // RULE17 fault blocks access
         rsp_fault      <= req_valid && (dec_fault != pgck_pkg::FLT_NONE);
         rsp_fault_code <= req_valid ? dec_fault : pgck_pkg::FLT_NONE;
         rsp_addr       <= (req_valid && dec_fault == pgck_pkg::FLT_NONE) ? dec_addr : '0;
         // RULE5 nested guest address
         rsp_guest_phys <= req_valid && ctrl_reg[pgck_pkg::CTRL_NEST_EN];
         // RULE9 forward coherent type
         rsp_mem_type   <= (req_valid && req_coherent) ? dec_type : 3'h0;
         // RULE10 write back flags
         upd_valid      <= req_valid && dec_upd_needed;
         upd_entry      <= req_valid ? dec_upd : upd_entry;
      end
   end

   // ----------------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------------
   // RULE8 global flag unused
   // The global page enable bit is stored only; nothing is cached, so it steers nothing.
   assign evt[pgck_pkg::EVT_FAULT]  = req_valid && (dec_fault != pgck_pkg::FLT_NONE);
   assign evt[pgck_pkg::EVT_DONE]   = req_valid && (dec_fault == pgck_pkg::FLT_NONE);
   assign evt[pgck_pkg::EVT_UPDATE] = req_valid && dec_upd_needed;

   // A new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 3'h0;
      end else if (wr_acc && paddr == pgck_pkg::OFS_STATUS) begin
         status_reg <= (status_reg & ~pwdata[pgck_pkg::EVT_W-1:0]) | evt;
      end else begin
         status_reg <= status_reg | evt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
         irq       <= 1'b0;
      end else begin
         if (evt[pgck_pkg::EVT_FAULT]) begin
            count_reg <= count_reg + 16'h0001;
         end
         irq <= |(status_reg & imask_reg);
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // RULE1 blocked fetch
   chk_exec_refused: assert property (@(posedge pclk) disable iff (!presetn)  // RULE1
      (req_valid && req_fetch && ctrl_reg[0] && req_entry[63] && req_entry[0] &&
       req_entry[2] | !req_user) |=> rsp_fault && (rsp_fault_code == pgck_pkg::FLT_EXEC ||
          rsp_fault_code == pgck_pkg::FLT_WRITE))
      else $error("fetch to blocked page not refused");

   // RULE12 user rejected
   chk_user_denied: assert property (@(posedge pclk) disable iff (!presetn)  // RULE12
      (req_valid && req_user && req_entry[0] && !req_entry[2]) |=>
         rsp_fault && rsp_fault_code == 3'h2)
      else $error("user access to supervisor page not rejected");

   // RULE13 user write denied
   chk_write_denied: assert property (@(posedge pclk) disable iff (!presetn)  // RULE13
      (req_valid && req_write && req_user && req_entry[2:0] == 3'h5) |=>
         rsp_fault_code == 3'h3)
      else $error("user write to read-only page not denied");

   // RULE17 absent entry
   chk_absent_fault: assert property (@(posedge pclk) disable iff (!presetn)  // RULE17
      (req_valid && !req_entry[0]) |=> rsp_fault && !upd_valid && rsp_addr == '0)
      else $error("absent entry not faulted");

   // RULE3 frame and offset
   chk_addr_frame: assert property (@(posedge pclk) disable iff (!presetn)  // RULE3
      (rsp_valid && !rsp_fault) |->
         rsp_addr == {$past(req_entry[HOST_ADDR_WIDTH-1:16]), $past(req_offset)})
      else $error("page address not frame joined to offset");

   // RULE10 dirty on write
   chk_dirty_set: assert property (@(posedge pclk) disable iff (!presetn)  // RULE10
      (req_valid && req_write && req_entry[2:0] == 3'h7) |=> upd_entry[6] && upd_entry[5])
      else $error("dirty flag not set by write");

   // RULE11 accessed on use
   chk_accessed_set: assert property (@(posedge pclk) disable iff (!presetn)  // RULE11
      (req_valid && req_entry[0] && req_entry[2] && !req_write && !req_entry[5] &&
       !(req_fetch && ctrl_reg[0] && req_entry[63])) |=>
         upd_valid && upd_entry[5] && !upd_entry[6] == !$past(req_entry[6]))
      else $error("accessed flag not set on first use");

   // RULE7 extended flag set
   chk_ext_flag: assert property (@(posedge pclk) disable iff (!presetn)  // RULE7
      (rsp_valid && !rsp_fault && upd_valid) |->
         upd_entry[10] == ($past(ctrl_reg[2]) | $past(req_entry[10])))
      else $error("extended access flag mishandled");

   // RULE5 guest address flag
   chk_nested_flag: assert property (@(posedge pclk) disable iff (!presetn)  // RULE5
      rsp_valid |-> rsp_guest_phys == $past(ctrl_reg[1]))
      else $error("guest address flag wrong");

   // RULE2 ignored bits kept
   chk_ignored_bits: assert property (@(posedge pclk) disable iff (!presetn)  // RULE2
      (rsp_valid && upd_valid) |-> upd_entry[63:52] == $past(req_entry[63:52]) &&
         upd_entry[9] == $past(req_entry[9]) && upd_entry[11] == $past(req_entry[11]))
      else $error("ignored bits altered");

   // RULE9 coherent type out
   chk_type_fwd: assert property ((req_valid && req_coherent) |=>  // RULE9
      rsp_mem_type == {$past(req_entry[7]), $past(req_entry[4]), $past(req_entry[3])})
      else $error("memory type not forwarded");

   // RULE9 plain type zero
   chk_type_plain: assert property ((req_valid && !req_coherent) |=>  // RULE9
      rsp_mem_type == 3'h0)
      else $error("memory type on non-coherent request");

   // RULE17 no request no answer
   chk_rsp_idle: assert property (!req_valid |=>  // RULE17
      !rsp_valid && !rsp_fault && !upd_valid)
      else $error("answer without request");

   // RULE17 fault blocks access
   chk_fault_quiet: assert property (rsp_fault |->  // RULE17
      !upd_valid && rsp_addr == '0)
      else $error("faulted request still granted");

   // RULE17 fault counted
   chk_fault_count: assert property (rsp_fault |->  // RULE17
      count_reg == $past(count_reg) + 16'h0001)
      else $error("fault not counted");

   // RULE17 fault event kept
   chk_fault_event: assert property (rsp_fault |->  // RULE17
      status_reg[pgck_pkg::EVT_FAULT])
      else $error("fault event lost");

   // RULE17 success event kept
   chk_done_event: assert property ((rsp_valid && !rsp_fault) |->  // RULE17
      status_reg[pgck_pkg::EVT_DONE])
      else $error("success event lost");

   // RULE13 supervisor write protect
   chk_sup_write: assert property ((req_valid && req_write && !req_user &&  // RULE13
      ctrl_reg[3] && req_entry[2:0] == 3'h5) |=> rsp_fault_code == pgck_pkg::FLT_WRITE)
      else $error("protected supervisor write not denied");

   // RULE14 supervisor path open
   chk_sup_free: assert property ((req_valid && !req_user && !req_fetch &&  // RULE14
      !ctrl_reg[3] && req_entry[0]) |=> !rsp_fault)
      else $error("supervisor request faulted");

   // RULE1 fetch allowed when off
   chk_exec_open: assert property ((req_valid && req_fetch && !ctrl_reg[0] &&  // RULE1
      req_entry[2:0] == 3'h7) |=> !rsp_fault)
      else $error("fetch refused with protection off");

   // RULE7 flag ignored when off
   chk_ext_ignored: assert property ((req_valid && !ctrl_reg[2]) |=>  // RULE7
      upd_entry[10] == $past(req_entry[10]))
      else $error("extended flag changed while disabled");

   // RULE10 reads leave dirty
   chk_read_clean: assert property ((req_valid && !req_write) |=>  // RULE10
      upd_entry[6] == $past(req_entry[6]))
      else $error("dirty flag set by read");

   // RULE8 global flag untouched
   chk_global_kept: assert property (req_valid |=>  // RULE8
      upd_entry[8] == $past(req_entry[8]))
      else $error("global flag acted upon");

endmodule : pgck_top

// >>> test/pgck_partner.sv
// Behavioural model of the requesting engine and its page-table memory.
`timescale 1ns/1ps
module pgck_partner (
   input  wire logic        pclk,
   input  wire logic        upd_valid,
   input  wire logic [63:0] upd_entry,
   output logic             req_valid,
   output logic [63:0]      req_entry,
   output logic [15:0]      req_offset,
   output logic             req_user,
   output logic             req_write,
   output logic             req_fetch,
   output logic             req_coherent
);
   logic [63:0] mem [8];
   logic [2:0]  cur;

   initial begin
      {req_valid, req_entry, req_offset} = '0;
      {req_user, req_write, req_fetch, req_coherent} = 4'h0;
      cur = 3'h0;
   end

   task automatic load(input logic [2:0] i, input logic [63:0] e);
      mem[i] = e & ~64'h000F_FF80_0000_F000;
   endtask : load

   // Released lines show the inverse so a late sample cannot pass by luck.
   task automatic issue(input logic [2:0] i, input logic [15:0] o, input logic [3:0] q);
      @(posedge pclk);
      cur <= i;
      {req_valid, req_entry, req_offset} <= {1'b1, mem[i], o};
      {req_user, req_write, req_fetch, req_coherent} <= q;
      @(posedge pclk);
      {req_valid, req_entry, req_offset} <= {1'b0, ~mem[i], ~o};
      {req_user, req_write, req_fetch, req_coherent} <= ~q;
   endtask : issue

   // The table takes back each entry the checker marks as used.
   always @(posedge pclk) begin
      if (upd_valid === 1'b1) begin
         mem[cur] <= upd_entry;
      end
   end
endmodule : pgck_partner

// >>> test/pgck_top_tb.sv
// Self-checking bench of the 64KB page entry checker.
`timescale 1ns/1ps
module pgck_top_tb;
   localparam int HOST_ADDR_WIDTH = pgck_pkg::HAW_CLIENT;
   localparam logic [63:0] BASE = 64'h0000_0012_3456_0007;
   localparam logic [15:0] OFS = 16'hA5C3;
   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata, rd;
   logic [63:0]    req_entry, upd_entry, e;
   logic [15:0]    req_offset;
   logic [HOST_ADDR_WIDTH-1:0] rsp_addr;
   logic [2:0]     rsp_fault_code, rsp_mem_type;
   logic [4:0]     ctrl = 5'h00;
   logic           pready, pslverr, req_valid, req_user, req_write, req_fetch;
   logic           req_coherent, rsp_valid, rsp_fault, rsp_guest_phys, upd_valid, irq, er;
   int             n_errors = 0;
   int             checked = 0;
   int             nf = 0;

   always #5 pclk = ~pclk;

   pgck_top #(.HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)) pgck_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_entry, .req_offset, .req_user,
      .req_write, .req_fetch, .req_coherent, .rsp_valid, .rsp_fault, .rsp_fault_code,
      .rsp_addr, .rsp_guest_phys, .rsp_mem_type, .upd_valid, .upd_entry, .irq);

   pgck_partner pgck_partner_inst (.pclk, .upd_valid, .upd_entry, .req_valid, .req_entry,
      .req_offset, .req_user, .req_write, .req_fetch, .req_coherent);

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, g, x);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk(64'(pready), 64'h1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(64'(rd), 64'(x));
      chk(64'(er), 64'h0);
   endtask : rdc

   task automatic setc(input logic [4:0] v);
      ctrl = v;
      apb(1'b1, pgck_pkg::OFS_CTRL, {27'h0, v});
   endtask : setc

   // Request fields q are user, write, fetch, coherent; c is the expected fault code.
   task automatic xq(input logic [2:0] i, input logic [3:0] q, input logic [2:0] c);
      logic [63:0] n;
      e = pgck_partner_inst.mem[i];
      n = e | 64'h20 | (q[2] ? 64'h40 : 64'h0) | (ctrl[2] ? 64'h400 : 64'h0);
      pgck_partner_inst.issue(i, OFS, q);
      #1;
      chk(64'(rsp_valid), 64'h1);
      chk(64'(rsp_fault_code), 64'(c));
      chk(64'(rsp_fault), 64'(c != 3'h0));
      chk(64'(rsp_addr), (c != 3'h0) ? 64'h0 : 64'({e[HOST_ADDR_WIDTH-1:16], OFS}));
      chk(64'(rsp_guest_phys), 64'(ctrl[1]));
      if (c == 3'h0) chk(64'(rsp_mem_type), q[0] ? 64'({e[7], e[4], e[3]}) : 64'h0);
      chk(64'(upd_valid), 64'(c == 3'h0 && n != e));
      if (upd_valid === 1'b1) chk(upd_entry, n);
      nf = nf + int'(c != 3'h0);
      @(posedge pclk);
      #1;
   endtask : xq

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(64'($bits(rsp_addr)), 64'h27);
      rdc(pgck_pkg::OFS_CTRL, 32'h0);
      rdc(pgck_pkg::OFS_IMASK, 32'h0);
      rdc(pgck_pkg::OFS_COUNT, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(64'(er), 64'h1);
      chk(64'(rd), 64'h0);
      pgck_partner_inst.load(3'd0, BASE | 64'h98);
      xq(3'd0, 4'b1001, 3'h0);
      xq(3'd0, 4'b1100, 3'h0);
      xq(3'd0, 4'b1001, 3'h0);
      setc(5'h10);
      pgck_partner_inst.load(3'd1, BASE | 64'h7FF0_0000_0000_0B98);
      xq(3'd1, 4'b1101, 3'h0);
      pgck_partner_inst.load(3'd2, BASE & ~64'h1);
      xq(3'd2, 4'b1000, 3'h1);
      pgck_partner_inst.load(3'd3, BASE & ~64'h4);
      xq(3'd3, 4'b1000, 3'h2);
      pgck_partner_inst.load(3'd4, BASE & ~64'h2);
      xq(3'd4, 4'b1100, 3'h3);
      xq(3'd4, 4'b0100, 3'h0);
      setc(5'h08);
      xq(3'd4, 4'b0100, 3'h3);
      pgck_partner_inst.load(3'd5, BASE | 64'h8000_0000_0000_0000);
      setc(5'h00);
      xq(3'd5, 4'b1010, 3'h0);
      setc(5'h01);
      xq(3'd5, 4'b1010, 3'h4);
      setc(5'h02);
      xq(3'd0, 4'b1001, 3'h0);
      setc(5'h04);
      xq(3'd0, 4'b1001, 3'h0);
      xq(3'd0, 4'b1001, 3'h0);
      rdc(pgck_pkg::OFS_COUNT, 32'(nf));
      // Interrupt path: clear, unmask faults, then swap the mask to successes.
      rdc(pgck_pkg::OFS_STATUS, 32'h7);
      apb(1'b1, pgck_pkg::OFS_STATUS, 32'h7);
      rdc(pgck_pkg::OFS_STATUS, 32'h0);
      apb(1'b1, pgck_pkg::OFS_IMASK, 32'h1);
      chk(64'(irq), 64'h0);
      xq(3'd2, 4'b1000, 3'h1);
      chk(64'(irq), 64'h1);
      rdc(pgck_pkg::OFS_STATUS, 32'h1);
      apb(1'b1, pgck_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      #1;
      chk(64'(irq), 64'h0);
      apb(1'b1, pgck_pkg::OFS_IMASK, 32'h2);
      xq(3'd2, 4'b1000, 3'h1);
      chk(64'(irq), 64'h0);
      xq(3'd0, 4'b1001, 3'h0);
      chk(64'(irq), 64'h1);
      rdc(pgck_pkg::OFS_STATUS, 32'h3);
      summarize();
   end

   // The whole sequence needs about 120 cycles; this bound is generous.
   initial begin
      #100us;
      n_errors++;
      summarize();
   end
endmodule : pgck_top_tb
